// [src/dual_legacy_counter_timer.v]
// Two legacy counter/timers with shared clock select and prescaler.
// Assumes event and gate pins are synchronous to clock_in and the register port is
// a single-cycle strobe master with read data one cycle later.
//
// Contract
// - prescale field picks clock/12, /4, /48 or external clock/8.
// - timer B clock select bit 3: prescaled or system clock.
// - timer A clock select bit 2: prescaled or system clock.
// - counter select counts falling edges on the event pin.
// - count only when run and gate is off or gate input active.
// - 13-bit mode uses high byte and low bits 4 to 0.
// - 13-bit wrap from 0x1fff sets overflow flag, may interrupt.
// - run bit never clears the count; software preloads it.
// - timer B mirrors timer A with its own bits and gate input.
// - 16-bit mode counts across both bytes.
// - reload mode wraps low byte, sets flag, reloads from high byte.
// - split mode low byte uses timer A controls and flag.
// - split high byte runs on timer B run, sets timer B flag.
// - in split, timer B counts internal only and never sets flag.
// - timer B mode 3 stops timer B.
// - overflow interrupts only when its enable bit is set.
// - clock control bits 7 to 4 drive timer 2 and 3 selects.
// - flags writable by software, cleared on interrupt vector.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "dual_timer_defines.vh"

module dual_legacy_counter_timer (
	// Clock and reset
	input  wire       clock_in,
	input  wire       rst_in,
	// Register port
	input  wire [7:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire       wr_in,
	input  wire       rd_in,
	output reg  [7:0] rdata_out,
	// Pins
	input  wire       event_pin_a_in,
	input  wire       event_pin_b_in,
	input  wire       gate_input_a_in,
	input  wire       gate_input_b_in,
	input  wire       ext_clock_in,
	// Interrupts and overflow pulses
	output reg        timer_a_irq_out,
	output reg        timer_b_irq_out,
	output reg        timer_b_overflow_out,
	// Clock selects for timers 2 to 5
	output reg        tmr2_low_clock_select_out,
	output reg        tmr2_high_clock_select_out,
	output reg        tmr3_low_clock_select_out,
	output reg        tmr3_high_clock_select_out,
	output reg        tmr4_low_clock_select_out,
	output reg        tmr4_high_clock_select_out,
	output reg        tmr5_low_clock_select_out,
	output reg        tmr5_high_clock_select_out
);

////////////////////////////////////////////////////////////////////////

reg  [7:0] timer_clock_select;
reg  [7:0] timer_clock_select_ext;
reg  [7:0] timer_control_reg;
reg  [7:0] timer_mode_reg;
reg  [7:0] interrupt_enable_reg;
reg  [1:0] gate_polarity;
reg  [7:0] timer_a_low_byte;
reg  [7:0] timer_a_high_byte;
reg  [7:0] timer_b_low_byte;
reg  [7:0] timer_b_high_byte;
reg  [5:0] div_count;
reg  [2:0] ext_div_count;
reg        ext_sync1;
reg        ext_sync2;
reg        ext_prev;
reg        event_prev_a;
reg        event_prev_b;

function wr_hit;
	input       strobe;
	input [7:0] addr;
	input [7:0] target;
	begin
		wr_hit = strobe && (addr == target);
	end
endfunction

// Decode from explicit ports so every process stays sensitive to the bus
wire hit_sel   = wr_hit(wr_in, addr_in, `ADDR_CLOCK_SELECT);
wire hit_sel_x = wr_hit(wr_in, addr_in, `ADDR_CLOCK_SELECT_EXT);
wire hit_ctl   = wr_hit(wr_in, addr_in, `ADDR_TIMER_CONTROL);
wire hit_mode  = wr_hit(wr_in, addr_in, `ADDR_TIMER_MODE);
wire hit_a_lo  = wr_hit(wr_in, addr_in, `ADDR_TIMER_A_LOW);
wire hit_a_hi  = wr_hit(wr_in, addr_in, `ADDR_TIMER_A_HIGH);
wire hit_b_lo  = wr_hit(wr_in, addr_in, `ADDR_TIMER_B_LOW);
wire hit_b_hi  = wr_hit(wr_in, addr_in, `ADDR_TIMER_B_HIGH);
wire hit_ie    = wr_hit(wr_in, addr_in, `ADDR_IRQ_ENABLE);
wire hit_pol   = wr_hit(wr_in, addr_in, `ADDR_GATE_POLARITY);
wire hit_ack   = wr_hit(wr_in, addr_in, `ADDR_IRQ_ACK);

////////////////////////////////////////////////////////////////////////
// Prescaler

wire ext_rise = ext_sync2 && !ext_prev;
wire [1:0] prescale_select = timer_clock_select[1:0];
reg        prescale_tick;
reg  [5:0] div_last;

always @* begin
	case (prescale_select)
	`PS_DIV12: div_last = `DIV12_LAST;
	`PS_DIV4:  div_last = `DIV4_LAST;
	`PS_DIV48: div_last = `DIV48_LAST;
	default:   div_last = `DIV12_LAST;
	endcase
	if (prescale_select == `PS_EXT8)
		prescale_tick = ext_rise && (ext_div_count == `EXT8_LAST);
	else
		prescale_tick = (div_count == div_last);
end

// External clock is foreign: two-stage sync before edge detection
always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		div_count     <= 6'h00;
		ext_div_count <= 3'h0;
		ext_sync1     <= 1'b0;
		ext_sync2     <= 1'b0;
		ext_prev      <= 1'b0;
		event_prev_a  <= 1'b0;
		event_prev_b  <= 1'b0;
	end else begin
		ext_sync1    <= ext_clock_in;
		ext_sync2    <= ext_sync1;
		ext_prev     <= ext_sync2;
		event_prev_a <= event_pin_a_in;
		event_prev_b <= event_pin_b_in;
		if (div_count >= div_last)
			div_count <= 6'h00;
		else
			div_count <= div_count + 6'h01;
		if (ext_rise)
			ext_div_count <= ext_div_count + 3'h1;
	end
end

////////////////////////////////////////////////////////////////////////
// Tick selection and enables

wire [1:0] mode_a = timer_mode_reg[`TM_A_MODE_HI:`TM_A_MODE_LO];
wire [1:0] mode_b = timer_mode_reg[`TM_B_MODE_HI:`TM_B_MODE_LO];
wire       split  = (mode_a == `MODE_SPLIT);
wire       a_run  = timer_control_reg[`TC_A_RUN];
wire       b_run  = timer_control_reg[`TC_B_RUN];

// pins are assumed held two cycles, so one-cycle history suffices
wire fall_a = event_prev_a && !event_pin_a_in;
wire fall_b = event_prev_b && !event_pin_b_in;

wire int_tick_a = timer_clock_select[`CS_TIMER_A] ? 1'b1 : prescale_tick;
wire int_tick_b = timer_clock_select[`CS_TIMER_B] ? 1'b1 : prescale_tick;

wire gate_ok_a = !timer_mode_reg[`TM_A_GATE] ||
	(gate_input_a_in == gate_polarity[`POL_A]);
// timer B gated by second input
wire gate_ok_b = !timer_mode_reg[`TM_B_GATE] ||
	(gate_input_b_in == gate_polarity[`POL_B]);

wire tick_a = timer_mode_reg[`TM_A_CSEL] ? fall_a : int_tick_a;
// no external edges for timer B in split
wire tick_b = (timer_mode_reg[`TM_B_CSEL] && !split) ? fall_b : int_tick_b;

wire inc_a  = a_run && gate_ok_a && tick_a;
// split high byte: internal tick, timer B run
wire inc_ah = split && b_run && int_tick_a;
// mode 3 stops B; in split B runs on its mode alone
wire inc_b  = (mode_b != `MODE_SPLIT) && tick_b &&
	(split ? 1'b1 : (b_run && gate_ok_b));

////////////////////////////////////////////////////////////////////////
// Counting, shared by both timers

reg  [7:0] next_a_low;
reg  [7:0] next_a_high;
reg  [7:0] next_b_low;
reg  [7:0] next_b_high;
reg        ovf_a;
reg        ovf_ah;
reg        ovf_b;

task step;
	input      [1:0] mode;
	input      [7:0] lo;
	input      [7:0] hi;
	output reg [7:0] nlo;
	output reg [7:0] nhi;
	output reg       ovf;
	reg        [12:0] c13;
	begin
		nlo = lo;
		nhi = hi;
		ovf = 1'b0;
		c13 = {hi, lo[4:0]};
		case (mode)
		`MODE_13BIT: begin
			ovf = (c13 == `TOP_13BIT);
			c13 = c13 + 13'h0001;
			nhi = c13[12:5];
			nlo = {lo[7:5], c13[4:0]};
		end
		`MODE_16BIT: begin
			ovf = ({hi, lo} == {`ONES_BYTE, `ONES_BYTE});
			{nhi, nlo} = {hi, lo} + 16'h0001;
		end
		`MODE_RELOAD: begin
			ovf = (lo == `ONES_BYTE);
			nlo = ovf ? hi : lo + 8'h01;
		end
		default: begin
			ovf = (lo == `ONES_BYTE);
			nlo = lo + 8'h01;
		end
		endcase
	end
endtask

// counts advance from loaded value only
always @* begin
	next_a_low  = timer_a_low_byte;
	next_a_high = timer_a_high_byte;
	next_b_low  = timer_b_low_byte;
	next_b_high = timer_b_high_byte;
	ovf_a  = 1'b0;
	ovf_ah = 1'b0;
	ovf_b  = 1'b0;
	if (inc_a)
		step(mode_a, timer_a_low_byte, timer_a_high_byte,
			next_a_low, next_a_high, ovf_a);
	if (inc_ah) begin
		ovf_ah      = (timer_a_high_byte == `ONES_BYTE);
		next_a_high = timer_a_high_byte + 8'h01;
	end
	if (inc_b)
		step(mode_b, timer_b_low_byte, timer_b_high_byte,
			next_b_low, next_b_high, ovf_b);
end

////////////////////////////////////////////////////////////////////////
// Registers

wire ack_a = hit_ack && wdata_in[`ACK_A];
wire ack_b = hit_ack && wdata_in[`ACK_B];
wire set_a = ovf_a;
// timer B own overflow never sets flag in split
wire set_b = split ? ovf_ah : ovf_b;
reg  [7:0] next_control;

// software write and vector clear; hardware set wins
always @* begin
	next_control = timer_control_reg;
	if (hit_ctl)
		next_control = wdata_in;
	if (ack_a)
		next_control[`TC_A_FLAG] = 1'b0;
	if (ack_b)
		next_control[`TC_B_FLAG] = 1'b0;
	if (set_a)
		next_control[`TC_A_FLAG] = 1'b1;
	if (set_b)
		next_control[`TC_B_FLAG] = 1'b1;
end

always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		timer_clock_select     <= `RESET_BYTE;
		timer_clock_select_ext <= `RESET_BYTE;
		timer_control_reg      <= `RESET_BYTE;
		timer_mode_reg         <= `RESET_BYTE;
		interrupt_enable_reg   <= `RESET_BYTE;
		gate_polarity          <= 2'h0;
		timer_a_low_byte       <= `RESET_BYTE;
		timer_a_high_byte      <= `RESET_BYTE;
		timer_b_low_byte       <= `RESET_BYTE;
		timer_b_high_byte      <= `RESET_BYTE;
	end else begin
		timer_control_reg <= next_control;
		// Software byte write overrides a same-cycle count
		timer_a_low_byte  <= hit_a_lo ? wdata_in : next_a_low;
		timer_a_high_byte <= hit_a_hi ? wdata_in : next_a_high;
		timer_b_low_byte  <= hit_b_lo ? wdata_in : next_b_low;
		timer_b_high_byte <= hit_b_hi ? wdata_in : next_b_high;
		if (hit_sel)
			timer_clock_select <= wdata_in;
		if (hit_sel_x)
			timer_clock_select_ext <= wdata_in & `EXT_WRITABLE;
		if (hit_mode)
			timer_mode_reg <= wdata_in;
		if (hit_ie)
			interrupt_enable_reg <= wdata_in;
		if (hit_pol)
			gate_polarity <= wdata_in[1:0];
	end
end

////////////////////////////////////////////////////////////////////////
// Read port and outputs

reg [7:0] read_mux;

always @* begin
	case (addr_in)
	`ADDR_CLOCK_SELECT:     read_mux = timer_clock_select;
	`ADDR_CLOCK_SELECT_EXT: read_mux = timer_clock_select_ext;
	`ADDR_TIMER_CONTROL:    read_mux = timer_control_reg;
	`ADDR_TIMER_MODE:       read_mux = timer_mode_reg;
	`ADDR_TIMER_A_LOW:      read_mux = timer_a_low_byte;
	`ADDR_TIMER_A_HIGH:     read_mux = timer_a_high_byte;
	`ADDR_TIMER_B_LOW:      read_mux = timer_b_low_byte;
	`ADDR_TIMER_B_HIGH:     read_mux = timer_b_high_byte;
	`ADDR_IRQ_ENABLE:       read_mux = interrupt_enable_reg;
	`ADDR_GATE_POLARITY:    read_mux = {6'h00, gate_polarity};
	default:                read_mux = `RESET_BYTE;
	endcase
end

always @(posedge clock_in or posedge rst_in) begin
	if (rst_in) begin
		rdata_out                  <= `RESET_BYTE;
		timer_a_irq_out            <= 1'b0;
		timer_b_irq_out            <= 1'b0;
		timer_b_overflow_out       <= 1'b0;
		tmr2_low_clock_select_out  <= 1'b0;
		tmr2_high_clock_select_out <= 1'b0;
		tmr3_low_clock_select_out  <= 1'b0;
		tmr3_high_clock_select_out <= 1'b0;
		tmr4_low_clock_select_out  <= 1'b0;
		tmr4_high_clock_select_out <= 1'b0;
		tmr5_low_clock_select_out  <= 1'b0;
		tmr5_high_clock_select_out <= 1'b0;
	end else begin
		rdata_out <= rd_in ? read_mux : `RESET_BYTE;
		timer_a_irq_out <= next_control[`TC_A_FLAG] &&
			interrupt_enable_reg[`IE_A];
		timer_b_irq_out <= next_control[`TC_B_FLAG] &&
			interrupt_enable_reg[`IE_B];
		// timer B overflow still serves other peripherals
		timer_b_overflow_out <= ovf_b;
		tmr2_low_clock_select_out  <= timer_clock_select[4];
		tmr2_high_clock_select_out <= timer_clock_select[5];
		tmr3_low_clock_select_out  <= timer_clock_select[6];
		tmr3_high_clock_select_out <= timer_clock_select[7];
		tmr4_low_clock_select_out  <= timer_clock_select_ext[0];
		tmr4_high_clock_select_out <= timer_clock_select_ext[1];
		tmr5_low_clock_select_out  <= timer_clock_select_ext[2];
		tmr5_high_clock_select_out <= timer_clock_select_ext[3];
	end
end

endmodule // dual_legacy_counter_timer

// [src/dual_timer_defines.vh]
// Constants for the dual legacy counter/timer block.
// Assumes inclusion by bare name from the design file.
`ifndef DUAL_TIMER_DEFINES_VH
`define DUAL_TIMER_DEFINES_VH
// Register offsets
`define ADDR_CLOCK_SELECT     8'h8e
`define ADDR_CLOCK_SELECT_EXT 8'he4
`define ADDR_TIMER_CONTROL    8'h88
`define ADDR_TIMER_MODE       8'h89
`define ADDR_TIMER_A_LOW      8'h8a
`define ADDR_TIMER_B_LOW      8'h8b
`define ADDR_TIMER_A_HIGH     8'h8c
`define ADDR_TIMER_B_HIGH     8'h8d
`define ADDR_IRQ_ENABLE       8'ha8
`define ADDR_GATE_POLARITY    8'he5
`define ADDR_IRQ_ACK          8'he6
// Field positions, clock select
`define CS_TIMER_A   2
`define CS_TIMER_B   3
// Field positions, control
`define TC_A_RUN     4
`define TC_A_FLAG    5
`define TC_B_RUN     6
`define TC_B_FLAG    7
// Field positions, mode register
`define TM_A_MODE_LO 0
`define TM_A_MODE_HI 1
`define TM_A_CSEL    2
`define TM_A_GATE    3
`define TM_B_MODE_LO 4
`define TM_B_MODE_HI 5
`define TM_B_CSEL    6
`define TM_B_GATE    7
// Irq enable, ack, polarity fields
`define IE_A         1
`define IE_B         3
`define ACK_A        0
`define ACK_B        1
`define POL_A        0
`define POL_B        1
// Mode encodings
`define MODE_13BIT   2'h0
`define MODE_16BIT   2'h1
`define MODE_RELOAD  2'h2
`define MODE_SPLIT   2'h3
// Prescale encodings and divide counts
`define PS_DIV12     2'h0
`define PS_DIV4      2'h1
`define PS_DIV48     2'h2
`define PS_EXT8      2'h3
`define DIV12_LAST   6'h0b
`define DIV4_LAST    6'h03
`define DIV48_LAST   6'h2f
`define EXT8_LAST    3'h7
// Misc
`define RESET_BYTE   8'h00
`define EXT_WRITABLE 8'h0f
`define TOP_13BIT    13'h1fff
`define ONES_BYTE    8'hff
`endif

// [dv/dlct_checker.sv]
// Assertions on the counter/timer register port and outputs.
// Assumes binding to the top module; sees only its ports.
`timescale 1ns/100ps
module dlct_checker (
	// Clock, reset and register port
	input wire       clock_in,
	input wire       rst_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	input wire       wr_in,
	input wire       rd_in,
	input wire [7:0] rdata_out,
	// Watched outputs
	input wire       timer_a_irq_out,
	input wire       timer_b_irq_out,
	input wire       tmr2_low_clock_select_out,
	input wire       tmr2_high_clock_select_out,
	input wire       tmr3_low_clock_select_out,
	input wire       tmr3_high_clock_select_out
);
	reg [7:0] clk_sel;
	reg [1:0] age;
	reg [1:0] run;
	reg [1:0] irq_en;
	wire      wr_ctl = wr_in && addr_in == 8'h88;
	wire      wr_ack = wr_in && addr_in == 8'he6;

	// Shadow of what software wrote; age counts edges since a select write
	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			clk_sel <= 8'h00;
			age <= 2'h3;
			run <= 2'h0;
			irq_en <= 2'h0;
		end else begin
			if (wr_in && addr_in == 8'h8e) clk_sel <= wdata_in;
			if (wr_in && addr_in == 8'h8e) age <= 2'h0;
			else if (age != 2'h3) age <= age + 2'h1;
			if (wr_ctl) run <= {wdata_in[6], wdata_in[4]};
			if (wr_in && addr_in == 8'ha8) irq_en <= {wdata_in[3], wdata_in[1]};
		end
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sel_pass_a: assert property (age == 2'h3 |->
		{tmr3_high_clock_select_out, tmr3_low_clock_select_out,
		tmr2_high_clock_select_out, tmr2_low_clock_select_out}
		== clk_sel[7:4]) else $error("clock select outputs differ");
	sel_read_a: assert property ($past(rd_in && addr_in == 8'h8e)
		|-> rdata_out == clk_sel) else $error("clock select read bad");
	ext_read_a: assert property ($past(rd_in && addr_in == 8'he4)
		|-> rdata_out[7:4] == 4'h0) else $error("ext select high bits set");
	mask_a_a: assert property (!irq_en[0] && !$past(irq_en[0])
		|-> !timer_a_irq_out) else $error("masked timer a irq");
	mask_b_a: assert property (!irq_en[1] && !$past(irq_en[1])
		|-> !timer_b_irq_out) else $error("masked timer b irq");
	flag_set_a: assert property (wr_ctl && wdata_in[5] && irq_en[0]
		|-> ##[1:2] timer_a_irq_out) else $error("flag write no irq");
	ack_a_a: assert property (wr_ack && wdata_in[0] && !run[0]
		|-> ##[1:2] !timer_a_irq_out) else $error("ack a left irq");
	ack_b_a: assert property (wr_ack && wdata_in[1] && !run[1]
		|-> ##[1:2] !timer_b_irq_out) else $error("ack b left irq");
endmodule // dlct_checker

bind dual_legacy_counter_timer dlct_checker dlct_checker_inst (
	.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
	.timer_a_irq_out, .timer_b_irq_out, .tmr2_low_clock_select_out,
	.tmr2_high_clock_select_out, .tmr3_low_clock_select_out,
	.tmr3_high_clock_select_out);

// [dv/pin_model.sv]
// Model of the event pins and external clock source.
// Assumes requests are one-cycle pulses at least eight cycles apart.
`timescale 1ns/100ps
module pin_model (
	// Clock and requests
	input  wire clock_in,
	input  wire pulse_a_in,
	input  wire pulse_b_in,
	input  wire ext_run_in,
	// Pins
	output wire event_pin_a_out,
	output wire event_pin_b_out,
	output wire ext_clock_out
);
	reg [2:0] low_a = 3'h0;
	reg [2:0] low_b = 3'h0;
	reg [1:0] phase = 2'h0;

	// levels held three cycles, clock at a quarter rate
	always @(posedge clock_in) begin
		low_a <= {low_a[1:0], pulse_a_in};
		low_b <= {low_b[1:0], pulse_b_in};
		phase <= ext_run_in ? phase + 2'h1 : 2'h0;
	end
	// Pins are pulled up when idle; clock stands low when stopped
	assign event_pin_a_out = ~|low_a;
	assign event_pin_b_out = ~|low_b;
	assign ext_clock_out = phase[1];
endmodule // pin_model

// [dv/tb_dual_legacy_counter_timer.sv]
// Directed bench for the dual counter/timer over its register port.
// Assumes pin_model drives the event and external clock pins.
`timescale 1ns/100ps
module tb_dual_legacy_counter_timer;
	reg        clock_in = 0;
	reg        rst_in = 1;
	reg  [7:0] addr_in = 0;
	reg  [7:0] wdata_in = 0;
	reg        wr_in = 0;
	reg        rd_in = 0;
	reg        pa = 0;
	reg        pb = 0;
	reg        xr = 0;
	reg        gate_a = 1;
	reg        gate_b = 1;
	wire [7:0] rdata_out;
	wire [7:0] sel;
	wire [2:0] obs;
	wire       ev_a;
	wire       ev_b;
	wire       xclk;
	integer    err_count = 0;
	integer    n_compared = 0;
	integer    k;
	integer    t;
	reg  [7:0] v0;
	reg  [7:0] v1;
	reg  [7:0] v2;
	reg  [7:0] v3;
	reg  [7:0] d;

	dual_legacy_counter_timer dual_legacy_counter_timer_inst (
		.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .event_pin_a_in(ev_a),
		.event_pin_b_in(ev_b), .gate_input_a_in(gate_a),
		.gate_input_b_in(gate_b), .ext_clock_in(xclk),
		.timer_a_irq_out(obs[0]), .timer_b_irq_out(obs[1]),
		.timer_b_overflow_out(obs[2]),
		.tmr2_low_clock_select_out(sel[4]),
		.tmr2_high_clock_select_out(sel[5]),
		.tmr3_low_clock_select_out(sel[6]),
		.tmr3_high_clock_select_out(sel[7]),
		.tmr4_low_clock_select_out(sel[0]),
		.tmr4_high_clock_select_out(sel[1]),
		.tmr5_low_clock_select_out(sel[2]),
		.tmr5_high_clock_select_out(sel[3]));
	pin_model pin_model_inst (.clock_in(clock_in), .pulse_a_in(pa),
		.pulse_b_in(pb), .ext_run_in(xr), .event_pin_a_out(ev_a),
		.event_pin_b_out(ev_b), .ext_clock_out(xclk));

	initial forever #10 clock_in = ~clock_in;

	////////////////////////////////////////////////////////////////////
	task close_out;
	begin
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input [7:0] a, input [7:0] e, input [7:0] s);
	begin
		n_compared = n_compared + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("CHECK FAILED item %h exp %h got %h", a, e, s);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] dt);
	begin
		@(posedge clock_in);
		wr_in <= 1;
		addr_in <= a;
		wdata_in <= dt;
		@(posedge clock_in);
		wr_in <= 0;
	end
	endtask
	task rd(input [7:0] a, output [7:0] dt);
	begin
		@(posedge clock_in);
		rd_in <= 1;
		addr_in <= a;
		@(posedge clock_in);
		rd_in <= 0;
		#1 dt = rdata_out;
	end
	endtask
	task rc(input [7:0] a, input [7:0] e);
	begin
		rd(a, v0);
		chk(a, e, v0);
	end
	endtask
	// Bounded wait for masked outputs to reach a value
	task wt(input [2:0] m, input [2:0] e);
	begin
		#1 t = 0;
		while (t < 40 && (obs & m) !== e) begin
			@(posedge clock_in);
			#1 t = t + 1;
		end
		chk(8'hee, {5'h0, e}, {5'h0, obs & m});
		if (t == 40) close_out;
	end
	endtask
	task ev(input b);
	begin
		@(posedge clock_in);
		if (b) pb <= 1;
		else pa <= 1;
		@(posedge clock_in);
		pa <= 0;
		pb <= 0;
		repeat (8) @(posedge clock_in);
	end
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clock_in);
		rst_in <= 0;
		rc(8'h8e, 8'h00);
		rc(8'h89, 8'h00);
		wr(8'he4, 8'hf5);
		rc(8'he4, 8'h05);
		wr(8'h8e, 8'ha0);
		rc(8'h8e, 8'ha0);
		chk(8'h8e, 8'ha5, sel);
		wr(8'h33, 8'h5a);
		rc(8'h33, 8'h00);
		$display("test registers done");
		// External clock first, while its divider is still at zero
		wr(8'h8e, 8'h03);
		wr(8'h89, 8'h11);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		xr <= 1;
		repeat (64) @(posedge clock_in);
		xr <= 0;
		repeat (10) @(posedge clock_in);
		rc(8'h8a, 8'h02);
		wr(8'h88, 8'h50);
		for (k = 0; k < 4; k = k + 1) begin
			d = k == 0 ? 4 : k == 1 ? 12 : k == 2 ? 1 : 48;
			wr(8'h8e, k == 3 ? 8'h0c : k[7:0]);
			rd(8'h8a, v0);
			rd(8'h8b, v1);
			repeat (44) @(posedge clock_in);
			rd(8'h8a, v2);
			rd(8'h8b, v3);
			chk(8'h8a, v0 + d, v2);
			chk(8'h8b, v1 + d, v3);
		end
		wr(8'h88, 8'h00);
		$display("test prescale done");
		wr(8'h89, 8'h04);
		wr(8'h8c, 8'hff);
		wr(8'h8a, 8'h1f);
		wr(8'ha8, 8'h02);
		wr(8'h88, 8'h10);
		ev(0);
		wt(3'h1, 3'h1);
		rd(8'h8a, v0);
		chk(8'h8a, 8'h00, v0 & 8'h1f);
		rc(8'h8c, 8'h00);
		ev(0);
		rd(8'h8a, v0);
		chk(8'h8a, 8'h01, v0 & 8'h1f);
		// Gate on, input inactive: first edge blocked, second counts
		wr(8'h89, 8'h0c);
		ev(0);
		gate_a <= 0;
		ev(0);
		rd(8'h8a, v0);
		chk(8'h8a, 8'h02, v0 & 8'h1f);
		wr(8'ha8, 8'h00);
		wt(3'h1, 3'h0);
		wr(8'ha8, 8'h02);
		wt(3'h1, 3'h1);
		wr(8'h88, 8'h20);
		wr(8'he6, 8'h01);
		wt(3'h1, 3'h0);
		rc(8'h88, 8'h00);
		$display("test thirteen bit done");
		wr(8'he5, 8'h00);
		wr(8'h89, 8'he4);
		wr(8'h8d, 8'h80);
		wr(8'h8b, 8'hff);
		wr(8'h88, 8'h40);
		ev(1);
		rc(8'h8b, 8'hff);
		@(posedge clock_in);
		gate_b <= 0;
		ev(1);
		rc(8'h8b, 8'h80);
		rc(8'h8d, 8'h80);
		rc(8'h88, 8'hc0);
		// Active-high polarity now makes the low gate input block
		wr(8'he5, 8'h02);
		ev(1);
		rc(8'h8b, 8'h80);
		wr(8'h88, 8'h00);
		wr(8'he6, 8'h02);
		rc(8'h88, 8'h00);
		$display("test reload done");
		wr(8'h8e, 8'h04);
		wr(8'h89, 8'h37);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'hfe);
		wr(8'h8b, 8'h55);
		wr(8'ha8, 8'h08);
		wr(8'h88, 8'h40);
		wt(3'h2, 3'h2);
		rc(8'h88, 8'hc0);
		wr(8'h88, 8'h00);
		rc(8'h8b, 8'h55);
		rc(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		ev(0);
		rc(8'h8a, 8'h01);
		wr(8'he6, 8'h02);
		wr(8'h8e, 8'h0c);
		wr(8'h8d, 8'hff);
		wr(8'h8b, 8'hfe);
		wr(8'h89, 8'h17);
		wt(3'h4, 3'h4);
		rc(8'h88, 8'h10);
		$display("test split done");
		close_out;
	end
endmodule // tb_dual_legacy_counter_timer
